// ==== design/cdad_pkg.sv ====
package cdad_pkg;

	// ---------------------------------------------------------------
	// Cluster shape
	// ---------------------------------------------------------------
	localparam int unsigned CDAD_MAX_CPUS = 4;
	localparam int unsigned CDAD_NUM_CPUS = 4;
	localparam int unsigned CDAD_AREA_BYTES = 4096;
	localparam int unsigned CDAD_WIN_BYTES = 2 * CDAD_AREA_BYTES;
	localparam int unsigned CDAD_REGION_BYTES = CDAD_NUM_CPUS * CDAD_WIN_BYTES;

	// ---------------------------------------------------------------
	// Address layout
	// ---------------------------------------------------------------
	localparam int unsigned CDAD_AREA_BIT = 12;
	localparam int unsigned CDAD_CPU_LSB = 13;
	localparam int unsigned CDAD_AW_1CPU = 13;
	localparam int unsigned CDAD_AW_2CPU = 14;
	localparam int unsigned CDAD_AW_34CPU = 15;
	localparam int unsigned CDAD_ADDR_W = (CDAD_NUM_CPUS == 1) ? CDAD_AW_1CPU :
		(CDAD_NUM_CPUS == 2) ? CDAD_AW_2CPU : CDAD_AW_34CPU;
	localparam int unsigned CDAD_CPU_W = (CDAD_ADDR_W > CDAD_CPU_LSB) ?
		CDAD_ADDR_W - CDAD_CPU_LSB : 1;
	localparam int unsigned CDAD_DATA_W = 32;
	localparam int unsigned CDAD_OFF_W = 12;

	localparam logic CDAD_AREA_DEBUG = 1'h0;
	localparam logic CDAD_AREA_PMON = 1'h1;

	typedef enum logic [1:0] {
		CDAD_IDLE,
		CDAD_SETUP,
		CDAD_ACCESS
	} cdad_phase_e;

endpackage

// ==== design/cdad_slot_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdad_slot_dec
	import cdad_pkg::*;
(
	input wire logic [CDAD_ADDR_W-1:0] addr,
	input wire logic sel,
	output logic [CDAD_MAX_CPUS-1:0] cpu_hit,
	output logic area_pmon,
	output logic slot_legal
);

	logic [1:0] cpu_idx;

	// --------------------------------------------------------------
	// Processor index from the upper address bits
	// --------------------------------------------------------------
	always_comb begin
		cpu_idx = 2'h0;
		if (CDAD_NUM_CPUS == 2) begin
			cpu_idx = {1'h0, addr[CDAD_CPU_LSB]};
		end else if (CDAD_NUM_CPUS > 2) begin
			cpu_idx = addr[CDAD_ADDR_W-1:CDAD_CPU_LSB];
		end
	end

	// Slot 3 of a three-processor build must stay dead even if selected
	assign slot_legal = (32'(cpu_idx) < CDAD_NUM_CPUS);
	assign area_pmon = addr[CDAD_AREA_BIT];

	genvar g;
	generate
		for (g = 0; g < CDAD_MAX_CPUS; g++) begin : g_hit
			assign cpu_hit[g] = sel && slot_legal && (cpu_idx == 2'(g)) &&
				(g < CDAD_NUM_CPUS);
		end
	endgenerate

endmodule
`default_nettype wire

// ==== design/cdad_cpu_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module cdad_cpu_port
	import cdad_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic debug_logic_reset_n_raw,
	output logic debug_logic_reset_n
);

	logic [1:0] sync_reg;

	// --------------------------------------------------------------
	// Reset bridge: asynchronous assert, synchronous release
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge debug_logic_reset_n_raw) begin
		if (!debug_logic_reset_n_raw) begin
			sync_reg <= 2'h0;
		end else if (!nrst) begin
			sync_reg <= 2'h0;
		end else begin
			sync_reg <= {sync_reg[0], 1'h1};
		end
	end

	assign debug_logic_reset_n = sync_reg[1];

endmodule
`default_nettype wire

// ==== design/cdad_top.sv ====
// Summary of operation
// - One shared APB port, taken on select
// - Region is eight KB per processor
// - Debug and monitor 4KB areas, contiguous
// - Address width 13, 14 or 15 bits
// - Bit 12 picks debug or monitor area
// - Two processors: bit 13 picks processor
// - Three processors: bits 14:13 pick 0-2
// - Four processors: bits 14:13 pick 0-3
// - Each processor debug interface exported separately
// - No trigger, powerup or lock-init pins
// - Per-processor active-low debug logic reset
`timescale 1ns/1ps
`default_nettype none
module cdad_top
	import cdad_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	// Shared debug APB slave
	input wire logic debug_port_select,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [CDAD_ADDR_W-1:0] debug_port_address,
	input wire logic [CDAD_DATA_W-1:0] pwdata,
	output logic [CDAD_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Per-processor debug resets, raw from the reset controller
	input wire logic [CDAD_NUM_CPUS-1:0] debug_logic_reset_n_in,
	output logic [CDAD_NUM_CPUS-1:0] debug_logic_reset_n,
	// Per-processor exported debug APB (area select plus 12-bit offset)
	output logic [CDAD_NUM_CPUS-1:0] cpu_dbg_sel,
	output logic [CDAD_NUM_CPUS-1:0] cpu_pmon_sel,
	output logic [CDAD_NUM_CPUS-1:0] cpu_penable,
	output logic [CDAD_NUM_CPUS-1:0] cpu_pwrite,
	output logic [CDAD_OFF_W-1:0] cpu_paddr,
	output logic [CDAD_DATA_W-1:0] cpu_pwdata,
	input wire logic [CDAD_NUM_CPUS*CDAD_DATA_W-1:0] cpu_prdata,
	input wire logic [CDAD_NUM_CPUS-1:0] cpu_pready,
	input wire logic [CDAD_NUM_CPUS-1:0] cpu_pslverr
);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	logic [CDAD_MAX_CPUS-1:0] cpu_hit;
	logic area_pmon;
	logic slot_legal;
	cdad_phase_e phase_reg;
	logic [CDAD_NUM_CPUS-1:0] hit_reg;
	logic pmon_reg;
	logic [CDAD_OFF_W-1:0] off_reg;
	logic [CDAD_DATA_W-1:0] wdata_reg;
	logic write_reg;
	logic [CDAD_DATA_W-1:0] rdata_mux;
	logic ready_mux;
	logic err_mux;
	logic setup_take;
	logic done;
	logic answer_take;
	logic resp_reg;
	logic err_reg;

	cdad_slot_dec u_dec (
		.addr(debug_port_address),
		.sel(debug_port_select),
		.cpu_hit(cpu_hit),
		.area_pmon(area_pmon),
		.slot_legal(slot_legal)
	);

	// Setup phase only; address is ignored while unselected
	assign setup_take = debug_port_select && !penable && (phase_reg != CDAD_ACCESS);

	// ---------------------------------------------------------------
	// Per-processor reset bridges
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CDAD_NUM_CPUS; g++) begin : g_cpu
			cdad_cpu_port u_rst (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.debug_logic_reset_n_raw(debug_logic_reset_n_in[g]),
				.debug_logic_reset_n(debug_logic_reset_n[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Transfer phase
	// ---------------------------------------------------------------
	assign done = (phase_reg == CDAD_ACCESS) && pready;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= CDAD_IDLE;
		end else begin
			unique case (phase_reg)
				CDAD_IDLE: begin
					if (setup_take) begin
						phase_reg <= CDAD_SETUP;
					end
				end
				CDAD_SETUP: begin
					if (!debug_port_select) begin
						phase_reg <= CDAD_IDLE;
					end else if (penable) begin
						phase_reg <= CDAD_ACCESS;
					end
				end
				CDAD_ACCESS: begin
					if (done) begin
						phase_reg <= CDAD_IDLE;
					end
				end
			endcase
		end
	end

	// Capture target at setup so a mid-transfer address change cannot re-route
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hit_reg <= '0;
			pmon_reg <= CDAD_AREA_DEBUG;
			off_reg <= '0;
			wdata_reg <= '0;
			write_reg <= 1'h0;
		end else if (setup_take && (phase_reg == CDAD_IDLE)) begin
			hit_reg <= cpu_hit[CDAD_NUM_CPUS-1:0];
			pmon_reg <= area_pmon;
			off_reg <= debug_port_address[CDAD_OFF_W-1:0];
			wdata_reg <= pwdata;
			write_reg <= pwrite;
		end else if (done || ((phase_reg == CDAD_SETUP) && !debug_port_select)) begin
			hit_reg <= '0;
		end
	end

	// ---------------------------------------------------------------
	// Exported per-processor ports
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < CDAD_NUM_CPUS; i++) begin
			cpu_dbg_sel[i] = hit_reg[i] && (pmon_reg == CDAD_AREA_DEBUG) &&
				(phase_reg != CDAD_IDLE);
			cpu_pmon_sel[i] = hit_reg[i] && (pmon_reg == CDAD_AREA_PMON) &&
				(phase_reg != CDAD_IDLE);
			cpu_penable[i] = hit_reg[i] && (phase_reg == CDAD_ACCESS) && !resp_reg;
			cpu_pwrite[i] = hit_reg[i] && write_reg;
		end
	end

	assign cpu_paddr = off_reg;
	assign cpu_pwdata = wdata_reg;

	// ---------------------------------------------------------------
	// Answer mux
	// ---------------------------------------------------------------
	always_comb begin
		rdata_mux = '0;
		ready_mux = 1'h1;
		err_mux = 1'h1;
		for (int i = 0; i < CDAD_NUM_CPUS; i++) begin
			if (hit_reg[i]) begin
				rdata_mux = cpu_prdata[i*CDAD_DATA_W +: CDAD_DATA_W];
				ready_mux = cpu_pready[i];
				err_mux = cpu_pslverr[i];
			end
		end
	end

	// ---------------------------------------------------------------
	// Answer register
	// ---------------------------------------------------------------
	// Read data comes from a flop, so the master sees pready one cycle
	// after the processor answers: one wait state buys a clean data path
	assign answer_take = (phase_reg == CDAD_ACCESS) && !resp_reg && ready_mux;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			resp_reg <= 1'h0;
		end else if (done) begin
			resp_reg <= 1'h0;
		end else if (answer_take) begin
			resp_reg <= 1'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			err_reg <= 1'h0;
		end else if (answer_take) begin
			err_reg <= err_mux;
		end
	end

	// Unmapped slot answers with an error after the one registered wait state rather than hanging the master
	assign pready = (phase_reg == CDAD_ACCESS) && resp_reg;
	assign pslverr = pready && err_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
		end else if (answer_take) begin
			prdata <= rdata_mux;
		end
	end

	// Trigger out, powered-up and lock-init pins are absent by design

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	region_size_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(1 << CDAD_ADDR_W) == CDAD_REGION_BYTES || CDAD_NUM_CPUS == 3)
		else $error("region size mismatch");

	addr_width_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		CDAD_ADDR_W == ((CDAD_NUM_CPUS == 1) ? 13 : (CDAD_NUM_CPUS == 2) ? 14 : 15))
		else $error("address width wrong");

	unsel_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && !debug_port_select) |=> (hit_reg == '0))
		else $error("target latched while unselected");

	one_target_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$onehot0(cpu_dbg_sel | cpu_pmon_sel))
		else $error("more than one target selected");

	area_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && setup_take && slot_legal && area_pmon)
		|=> (cpu_dbg_sel == '0) && (cpu_pmon_sel != '0))
		else $error("monitor area not routed");

	cpu_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && setup_take && slot_legal)
		|=> hit_reg == cpu_hit[CDAD_NUM_CPUS-1:0] && hit_reg != '0)
		else $error("processor not selected");

	dead_slot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && setup_take && !slot_legal)
		|=> (hit_reg == '0) ##1 (!pready || pslverr))
		else $error("dead slot reached a processor");

	access_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_SETUP && debug_port_select && penable)
		|=> (phase_reg == CDAD_ACCESS) && (cpu_penable == hit_reg))
		else $error("access phase not forwarded");

	reset_split_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(debug_logic_reset_n_in[0]) |-> ##[0:1] !debug_logic_reset_n[0])
		else $error("debug reset not applied");

	answer_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		answer_take |=> pready && (cpu_penable == '0))
		else $error("answer not passed to master");

	rdata_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		answer_take |=> (prdata == $past(rdata_mux)))
		else $error("read data not loaded");

	idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg != CDAD_ACCESS) |-> !pready && !pslverr)
		else $error("answer outside access phase");

	err_ready_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		pslverr |-> pready)
		else $error("error without ready");

	debug_area_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && setup_take && slot_legal && !area_pmon)
		|=> (cpu_pmon_sel == '0) && (cpu_dbg_sel != '0))
		else $error("debug area not routed");

	write_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(phase_reg == CDAD_IDLE && setup_take && slot_legal && pwrite)
		|=> (cpu_pwrite == hit_reg) && (hit_reg != '0))
		else $error("write flag not forwarded");

	hit_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		done |=> (hit_reg == '0))
		else $error("target kept after transfer");

	hit_onehot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$onehot0(hit_reg))
		else $error("several processors hit");

	release_delay_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!debug_logic_reset_n_in[0] |=> !debug_logic_reset_n[0])
		else $error("debug reset released early");

endmodule
`default_nettype wire

// ==== tb/cdad_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------
// Per-processor register areas, wait-state capable
// -----------------------------------------
module cdad_cpu_model
	import cdad_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [CDAD_NUM_CPUS-1:0] cpu_dbg_sel,
	input wire logic [CDAD_NUM_CPUS-1:0] cpu_pmon_sel,
	input wire logic [CDAD_NUM_CPUS-1:0] cpu_penable,
	input wire logic [CDAD_OFF_W-1:0] cpu_paddr,
	input wire logic [3:0] wait_cycles,
	output logic [CDAD_NUM_CPUS*CDAD_DATA_W-1:0] cpu_prdata,
	output logic [CDAD_NUM_CPUS-1:0] cpu_pready,
	output logic [CDAD_NUM_CPUS-1:0] cpu_pslverr
);
	logic [3:0] wait_reg;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wait_reg <= 4'h0;
		end else if (|cpu_penable && !(|cpu_pready)) begin
			wait_reg <= wait_reg + 4'h1;
		end else begin
			wait_reg <= 4'h0;
		end
	end
	// Answer only in access phase; data inverted when not ready
	always_comb begin
		for (int i = 0; i < CDAD_NUM_CPUS; i++) begin
			cpu_pready[i] = cpu_penable[i] && (cpu_dbg_sel[i] || cpu_pmon_sel[i]) &&
				(wait_reg >= wait_cycles);
			cpu_pslverr[i] = cpu_pready[i] && (cpu_paddr == 12'hfff);
			cpu_prdata[i*32 +: 32] = {4'ha, 2'(i), cpu_pmon_sel[i], 13'h0, cpu_paddr};
			if (!cpu_pready[i]) begin
				cpu_prdata[i*32 +: 32] = ~cpu_prdata[i*32 +: 32];
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/cluster_debug_apb_decode_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module cluster_debug_apb_decode_bench
	import cdad_pkg::*;
;
	logic sys_clk, nrst, debug_port_select, penable, pwrite;
	logic [CDAD_ADDR_W-1:0] debug_port_address;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic [3:0] debug_logic_reset_n_in, debug_logic_reset_n, wait_cycles;
	logic [3:0] cpu_dbg_sel, cpu_pmon_sel, cpu_penable, cpu_pwrite, cpu_pready, cpu_pslverr;
	logic [11:0] cpu_paddr;
	logic [31:0] cpu_pwdata;
	logic [127:0] cpu_prdata;
	int failures = 0;
	int tests_run = 0;

	cdad_top uut (.sys_clk(sys_clk), .nrst(nrst), .debug_port_select(debug_port_select),
		.penable(penable), .pwrite(pwrite), .debug_port_address(debug_port_address),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_logic_reset_n_in(debug_logic_reset_n_in),
		.debug_logic_reset_n(debug_logic_reset_n), .cpu_dbg_sel(cpu_dbg_sel),
		.cpu_pmon_sel(cpu_pmon_sel), .cpu_penable(cpu_penable), .cpu_pwrite(cpu_pwrite),
		.cpu_paddr(cpu_paddr), .cpu_pwdata(cpu_pwdata), .cpu_prdata(cpu_prdata),
		.cpu_pready(cpu_pready), .cpu_pslverr(cpu_pslverr));
	cdad_cpu_model cpus (.sys_clk(sys_clk), .nrst(nrst), .cpu_dbg_sel(cpu_dbg_sel),
		.cpu_pmon_sel(cpu_pmon_sel), .cpu_penable(cpu_penable), .cpu_paddr(cpu_paddr),
		.wait_cycles(wait_cycles), .cpu_prdata(cpu_prdata), .cpu_pready(cpu_pready),
		.cpu_pslverr(cpu_pslverr));

	// -----------------------------------------
	// Shared tasks
	// -----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Holds select after completion so a following call is back to back
	task automatic apb(input logic [14:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] ws);
		int n;
		logic [3:0] hot;
		hot = 4'h1 << a[14:13];
		wait_cycles <= ws;
		debug_port_select <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		debug_port_address <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 30);
		chk("pready", 32'(pready), 32'h1);
		chk("wait", 32'(n), 32'(ws) + 32'h3);
		chk("dbg_sel", 32'(cpu_dbg_sel), a[12] ? 32'h0 : 32'(hot));
		chk("pmon_sel", 32'(cpu_pmon_sel), a[12] ? 32'(hot) : 32'h0);
		chk("paddr", 32'(cpu_paddr), 32'(a[11:0]));
		chk("pwrite", 32'(cpu_pwrite[a[14:13]]), 32'(w));
		chk("pslverr", 32'(pslverr), 32'(a[11:0] == 12'hfff));
		if (w) chk("pwdata", cpu_pwdata, d);
		else chk("prdata", prdata, {4'ha, a[14:12], 13'h0, a[11:0]});
	endtask

	task automatic idle();
		debug_port_select <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// -----------------------------------------
	// Scenarios
	// -----------------------------------------
	task automatic t_map();
		chk("addr_w", $bits(debug_port_address), 32'd15);
		for (int c = 0; c < 4; c++) begin
			for (int ar = 0; ar < 2; ar++) begin
				apb({2'(c), 1'(ar), 12'h0a5 + 12'(c)}, 1'b0, 32'h0, 4'(c));
			end
		end
		idle();
		$display("map test done");
	endtask

	task automatic t_write();
		apb(15'h7ffe, 1'b1, 32'hdeadbeef, 4'h2);
		apb(15'h0001, 1'b1, 32'h12345678, 4'h0);
		idle();
		$display("write test done");
	endtask

	// Bus activity while unselected must reach no processor
	task automatic t_unsel();
		debug_port_address <= 15'h2abc;
		penable <= 1'b1;
		repeat (4) begin
			@(posedge sys_clk);
			chk("unsel_sel", 32'(cpu_dbg_sel | cpu_pmon_sel), 32'h0);
			chk("unsel_rdy", 32'(pready), 32'h0);
		end
		idle();
		$display("unselected test done");
	endtask

	task automatic t_err();
		apb(15'h5fff, 1'b0, 32'h0, 4'h1);
		apb(15'h5ffe, 1'b0, 32'h0, 4'h0);
		idle();
		$display("error test done");
	endtask

	task automatic t_rst();
		chk("dreset_idle", 32'(debug_logic_reset_n), 32'hf);
		debug_logic_reset_n_in <= 4'ha;
		@(posedge sys_clk);
		#1 chk("dreset_one", 32'(debug_logic_reset_n), 32'ha);
		@(posedge sys_clk);
		debug_logic_reset_n_in <= 4'hf;
		@(posedge sys_clk);
		chk("dreset_hold", 32'(debug_logic_reset_n), 32'ha);
		repeat (2) @(posedge sys_clk);
		chk("dreset_free", 32'(debug_logic_reset_n), 32'hf);
		$display("debug reset test done");
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		#50000;
		failures++;
		close_out();
	end

	// Four processors: every slot is legal, so the master never needs to avoid one
	initial begin
		nrst = 1'b0;
		debug_port_select = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		debug_port_address = '0;
		pwdata = '0;
		wait_cycles = 4'h0;
		debug_logic_reset_n_in = 4'hf;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_map();
		t_write();
		t_unsel();
		t_err();
		t_rst();
		close_out();
	end
endmodule
`default_nettype wire
